// file: btm_defines.svh
// Constants of the peripheral bus timeout monitor: offsets, fields, resets.
// Assumes inclusion by bare name; definitions only.
`ifndef BTM_DEFINES_SVH
`define BTM_DEFINES_SVH

// ****************************************************************
// Register offsets (byte addresses, word aligned)
// ****************************************************************
`define BTM_OFF_CONTROL     4'h0
`define BTM_OFF_STATUS      4'h4
`define BTM_OFF_IRQ_CLEAR   4'h8
`define BTM_OFF_IRQ_ENABLE  4'hC

// ****************************************************************
// Control fields and reset value
// ****************************************************************
`define BTM_ENABLE_BIT      3
`define BTM_SELECT_MSB      2
`define BTM_SELECT_LSB      0
`define BTM_CONTROL_WIDTH   16
`define BTM_CONTROL_RESET   16'h0008

// ****************************************************************
// Status fields and counts
// ****************************************************************
`define BTM_STAT_TIMEOUT    0
`define BTM_STAT_LATE_END   1
`define BTM_STAT_WIDTH      2
`define BTM_COUNT_WIDTH     11
`define BTM_MAX_TIMEOUT     11'h400

`endif

// file: btm_pkg.sv
// Types shared by the peripheral bus timeout monitor.
// Assumes btm_defines.svh for field widths.
`include "btm_defines.svh"

package btm_pkg;

  typedef logic [`BTM_COUNT_WIDTH-1:0] btm_count_t;

  typedef struct packed {
    logic       monitor_enable;
    logic [2:0] timeout_select;
  } btm_config_s;

  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } btm_avl_req_s;

  typedef enum logic [1:0] {
    BTM_IDLE,
    BTM_OPEN,
    BTM_ERROR
  } btm_state_e;

endpackage

// file: btm_decode.sv
// Timeout select decoder: turns the three-bit select field into a count.
// Assumes the select value is already registered.
`timescale 1ns/100ps
`default_nettype none
`include "btm_defines.svh"

module btm_decode (
  input  wire logic [2:0]      timeout_select,
  output logic [`BTM_COUNT_WIDTH-1:0] limit
);

  // 000 gives 1024 cycles and each step halves it down to 8.
  always_comb begin
    limit = `BTM_MAX_TIMEOUT >> timeout_select;  // see [RL7] see [RL5]
  end

endmodule

`default_nettype wire

// file: btm_monitor.sv
// Peripheral bus timeout monitor with its Avalon-MM register slave.
// Assumes one 50 MHz clock; the system bus and peripheral signals are
// synchronous to it; btm_defines.svh and btm_pkg are compiled first.
//
// Implementation choices: the address map and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
`include "btm_defines.svh"

// Function
// [RL1] Every peripheral bus cycle is watched with a count that restarts for each new cycle.
// [RL2] Counting starts when any module select first rises and runs until the wait signal falls.
// [RL3] Reaching the programmed count before the peripheral ends the cycle closes it with an error.
// [RL4] The error closure is passed to the system bus as an error response to the core.
// [RL5] The timeout is programmable from eight to 1024 system bus cycles.
// [RL6] Control bit 3 turns timeout checking off when 0 and on when 1.
// [RL7] Select bits 2 to 0 give 1024, 512, 256, 128, 64, 32, 16 or 8 cycles for codes 000 to 111.
// [RL8] After reset the monitor is enabled with the longest timeout.
// [RL9] Software should choose a timeout longer than the slowest peripheral response.
// [RL10] With the monitor disabled a cycle is never ended by elapsed time.
module btm_monitor (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic [1:0]       avs_response,
  output logic             avs_waitrequest,
  input  wire logic [7:0]  module_select,
  input  wire logic        xfr_wait,
  output logic             xfr_done,
  output logic             xfr_error,
  output logic             irq
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  btm_pkg::btm_avl_req_s               req;
  btm_pkg::btm_config_s                cfg;
  btm_pkg::btm_state_e                 state;
  btm_pkg::btm_count_t                 count;
  logic [`BTM_COUNT_WIDTH-1:0]         limit;
  logic [`BTM_STAT_WIDTH-1:0]          status;
  logic [`BTM_STAT_WIDTH-1:0]          irq_enable;
  logic [`BTM_STAT_WIDTH-1:0]          event_set;
  logic                                access_done;
  logic                                select_any;
  logic                                select_prev;
  logic                                cycle_start;
  logic                                timed_out;
  logic                                do_write;
  logic                                do_read;

  // Reset image of the control register, so its fields can be selected.
  localparam logic [`BTM_CONTROL_WIDTH-1:0] CONTROL_RESET = `BTM_CONTROL_RESET;

  assign req = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata};

  // ****************************************************************
  // Register slave
  // ****************************************************************
  // Each access is answered one cycle after it is presented: the first
  // cycle waits, the second drops waitrequest and completes.
  assign do_write = req.write && !avs_waitrequest;
  assign do_read  = req.read && !avs_waitrequest;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
    end else if ((req.read || req.write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg <= '{monitor_enable: CONTROL_RESET[`BTM_ENABLE_BIT],
               timeout_select: CONTROL_RESET[`BTM_SELECT_MSB:`BTM_SELECT_LSB]};  // see [RL8]
    end else if (do_write && req.address == `BTM_OFF_CONTROL) begin
      cfg.monitor_enable <= req.writedata[`BTM_ENABLE_BIT];  // see [RL6]
      cfg.timeout_select <= req.writedata[`BTM_SELECT_MSB:`BTM_SELECT_LSB];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_enable <= '0;
    end else if (do_write && req.address == `BTM_OFF_IRQ_ENABLE) begin
      irq_enable <= req.writedata[`BTM_STAT_WIDTH-1:0];
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= '0;
      avs_response <= 2'h0;
    end else begin
      avs_readdata <= '0;
      avs_response <= 2'h0;
      if ((req.read || req.write) && avs_waitrequest) begin
        unique case (req.address)
          `BTM_OFF_CONTROL: begin
            avs_readdata[`BTM_ENABLE_BIT] <= req.read & cfg.monitor_enable;
            avs_readdata[`BTM_SELECT_MSB:`BTM_SELECT_LSB] <=
              req.read ? cfg.timeout_select : 3'h0;
          end
          `BTM_OFF_STATUS: begin
            avs_readdata[`BTM_STAT_WIDTH-1:0] <= req.read ? status : 2'h0;
          end
          `BTM_OFF_IRQ_ENABLE: begin
            avs_readdata[`BTM_STAT_WIDTH-1:0] <= req.read ? irq_enable : 2'h0;
          end
          `BTM_OFF_IRQ_CLEAR: begin
            avs_readdata <= '0;
          end
          default: begin
            avs_response <= 2'h2;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Cycle monitor
  // ****************************************************************
  btm_decode u_decode (
    .timeout_select (cfg.timeout_select),
    .limit          (limit)
  );

  assign select_any  = |module_select;
  assign cycle_start = select_any && !select_prev;  // see [RL2]
  assign timed_out   = cfg.monitor_enable && (count + 11'h001 >= limit);  // see [RL3] see [RL10]

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      select_prev <= 1'b0;
    end else begin
      select_prev <= select_any;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= btm_pkg::BTM_IDLE;
      count <= '0;
    end else begin
      unique case (state)
        btm_pkg::BTM_IDLE: begin
          if (cycle_start) begin
            state <= btm_pkg::BTM_OPEN;
            count <= 11'h001;  // see [RL1]
          end
        end
        btm_pkg::BTM_OPEN: begin
          if (!xfr_wait) begin
            state <= btm_pkg::BTM_IDLE;  // see [RL2]
            count <= '0;
          end else if (timed_out) begin
            state <= btm_pkg::BTM_ERROR;  // see [RL3]
            count <= '0;
          end else if (count != `BTM_MAX_TIMEOUT) begin
            count <= count + 11'h001;
          end
        end
        btm_pkg::BTM_ERROR: begin
          if (!select_any) begin
            state <= btm_pkg::BTM_IDLE;
          end
        end
      endcase
    end
  end

  // Termination pulses towards the system bus side.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      xfr_done  <= 1'b0;
      xfr_error <= 1'b0;
    end else begin
      xfr_done  <= (state == btm_pkg::BTM_OPEN) && (!xfr_wait || timed_out);
      xfr_error <= (state == btm_pkg::BTM_OPEN) && xfr_wait && timed_out;  // see [RL4]
    end
  end

  // ****************************************************************
  // Interrupt status
  // ****************************************************************
  // Bit 0: a cycle was ended by timeout. Bit 1: a cycle ended normally
  // after running longer than half the limit, a hint to raise it.
  assign access_done = (state == btm_pkg::BTM_OPEN) && !xfr_wait;
  assign event_set[`BTM_STAT_TIMEOUT]  = (state == btm_pkg::BTM_OPEN) && xfr_wait && timed_out;
  assign event_set[`BTM_STAT_LATE_END] = access_done && (count > (limit >> 1));

  // A new event wins over a clear written in the same cycle.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      status <= '0;
    end else if (do_write && req.address == `BTM_OFF_IRQ_CLEAR) begin
      status <= (status & ~req.writedata[`BTM_STAT_WIDTH-1:0]) | event_set;
    end else begin
      status <= status | event_set;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & irq_enable);
    end
  end

endmodule

`default_nettype wire

// file: btm_monitor_sva.sv
// Checker of the timeout monitor ports.
// Assumes it is bound to btm_monitor.
`timescale 1ns/100ps
`default_nettype none
module btm_monitor_sva (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic [1:0]  avs_response,
  input wire logic        avs_waitrequest,
  input wire logic [7:0]  module_select,
  input wire logic        xfr_wait,
  input wire logic        xfr_done,
  input wire logic        xfr_error
);
  logic        en, open, sel_q;
  logic [2:0]  ts;
  logic [10:0] cnt;
  wire  [10:0] lim = 11'h400 >> ts;
  wire         tk = !avs_waitrequest && avs_write && avs_address == 4'h0;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      en <= 1'b1;
      ts <= 3'h0;
    end else if (tk) begin
      en <= avs_writedata[3];
      ts <= avs_writedata[2:0];
    end
  end
  // Mirrors the open peripheral cycle and its count from the select rise.
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q <= 1'b0;
      open <= 1'b0;
      cnt <= 11'h000;
    end else begin
      sel_q <= |module_select;
      if ((|module_select) && !sel_q) begin
        open <= 1'b1;
        cnt <= 11'h001;
      end else if (xfr_done) open <= 1'b0;
      else if (open) cnt <= cnt + 11'h001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  chk_bus_answer: assert property (s_req |=> s_answer)
    else $error("bus answer late");
  chk_bus_response: assert property (!avs_waitrequest |->
    avs_response == (avs_address[1:0] != 2'h0 ? 2'h2 : 2'h0)) else $error("bad response");
  chk_ctrl_readback: assert property (!avs_waitrequest && avs_read &&
    avs_address == 4'h0 |-> avs_readdata == {28'h0, en, ts}) else $error("bad control");
  chk_error_done: assert property (xfr_error |-> xfr_done)
    else $error("error without done");
  chk_done_pulse: assert property (xfr_done |=> !xfr_done)
    else $error("done too long");
  chk_normal_end: assert property (open && !xfr_wait && !xfr_done
    |=> xfr_done && !xfr_error) else $error("end not passed");
  chk_timeout_count: assert property (xfr_error |->
    cnt >= lim && cnt <= lim + 11'h002) else $error("timeout count wrong");
  chk_no_early_end: assert property (open && xfr_wait && cnt + 11'h002 < lim
    |=> !xfr_done) else $error("early end");
  chk_disabled_quiet: assert property (!en |-> !xfr_error)
    else $error("error while disabled");
endmodule
`default_nettype wire

// file: btm_periph_model.sv
// Peripheral model: one select and the wait handshake per access.
// Assumes the bench calls access right after a rising edge.
`timescale 1ns/100ps
`default_nettype none
module btm_periph_model (
  input  wire logic       sys_clk,
  input  wire logic       xfr_done,
  input  wire logic       xfr_error,
  output logic [7:0]      module_select,
  output logic            xfr_wait
);
  initial begin
    module_select = 8'h00;
    xfr_wait = 1'b1;
  end
  // Wait falls after dly edges unless the monitor ends the cycle first.
  task automatic access(input int idx, input int dly, output int n, output logic err);
    module_select <= 8'h01 << idx;
    xfr_wait <= 1'b1;
    n = 0;
    while (xfr_done !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      n++;
      if (n == dly) xfr_wait <= 1'b0;
    end
    err = xfr_error;
    module_select <= 8'h00;
    xfr_wait <= 1'b1;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// file: btm_monitor_tb.sv
// Self-checking bench of the timeout monitor.
// Assumes the package, design, model and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module btm_monitor_tb;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic [1:0]  avs_response, r;
  logic        avs_waitrequest, xfr_done, xfr_error, irq, xfr_wait, e;
  logic [7:0]  module_select;
  int          error_cnt = 0, n_tests = 0, cyc = 0, n;
  always #10 sys_clk = ~sys_clk;
  btm_monitor dut (.*);
  btm_periph_model pm (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic stop_test;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic t_reset;
    bus(1'b0, 4'h0, 32'h0);
    chk(q, 32'h8, "control reset");
    bus(1'b0, 4'h2, 32'h0);
    chk({q[29:0], r}, 32'h2, "unmapped read");
    $display("test reset done");
  endtask
  task automatic t_normal;
    pm.access(3, 5, n, e);
    chk({e, 31'(n)}, 32'h7, "normal end");
    pm.access(7, 1, n, e);
    chk({e, 31'(n)}, 32'h3, "second end");
    $display("test normal done");
  endtask
  task automatic t_codes;
    for (int s = 0; s < 8; s++) begin
      bus(1'b1, 4'h0, 32'h8 | s);
      pm.access(s, 2000, n, e);
      chk(e, 1'b1, "no timeout");
      chk(32'(n > (1024 >> s) && n < (1024 >> s) + 4), 32'h1, "timeout length");
      bus(1'b0, 4'h4, 32'h0);
      chk(q[0], 1'b1, "status not set");
      bus(1'b1, 4'h8, 32'h1);
    end
    $display("test codes done");
  endtask
  task automatic t_disabled;
    bus(1'b1, 4'h0, 32'h7);
    pm.access(0, 40, n, e);
    chk({e, 31'(n)}, 32'd42, "disabled end");
    $display("test disabled done");
  endtask
  task automatic t_irq;
    bus(1'b1, 4'h0, 32'hF);
    bus(1'b1, 4'hC, 32'h1);
    pm.access(1, 2000, n, e);
    bus(1'b0, 4'h4, 32'h0);
    chk(irq, 1'b1, "irq missing");
    bus(1'b1, 4'h8, 32'h3);
    bus(1'b0, 4'h4, 32'h0);
    chk({q[30:0], irq}, 32'h0, "irq not cleared");
    bus(1'b1, 4'hC, 32'h0);
    pm.access(2, 2000, n, e);
    bus(1'b0, 4'h4, 32'h0);
    chk({q[30:0], irq}, 32'h2, "masked irq");
    $display("test irq done");
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      stop_test;
    end
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_normal;
    t_codes;
    t_disabled;
    t_irq;
    stop_test;
  end
endmodule
bind btm_monitor btm_monitor_sva u_sva (.*);
`default_nettype wire
